// ### tar_pkg.sv
// Constants and types shared by the touch ADC result buffer
package tar_pkg;
   localparam int          TAR_DEPTH       = 64;
   localparam int          TAR_PTR_W       = 6;
   localparam int          TAR_CNT_W       = 7;
   localparam int          TAR_RES_W       = 12;
   localparam int          TAR_ENTRY_W     = 13;
   localparam int          TAR_WORD_W      = 16;
   localparam int          TAR_FULL_BIT    = 15;
   localparam int          TAR_EMPTY_BIT   = 14;
   localparam int          TAR_RSVD_BIT    = 13;
   localparam int          TAR_TAG_BIT     = 12;
   localparam logic [15:0] TAR_RESET_WORD  = 16'h4000;
   localparam logic [6:0]  TAR_CNT_FULL    = 7'h40;
   localparam logic [6:0]  TAR_CNT_ONE     = 7'h01;
   localparam logic [6:0]  TAR_CNT_ZERO    = 7'h00;

   // Measurement that produced a result
   typedef enum logic [3:0] {
      TAR_KIND_X       = 4'h0,
      TAR_KIND_Y       = 4'h1,
      TAR_KIND_PS1     = 4'h2,
      TAR_KIND_PS2     = 4'h3,
      TAR_KIND_BATTERY = 4'h4,
      TAR_KIND_AUX_ONE = 4'h5,
      TAR_KIND_AUX_TWO = 4'h6,
      TAR_KIND_TEMP    = 4'h7
   } tar_kind_type;
endpackage : tar_pkg

// ### tar_fifo.sv
// Parameterised flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module tar_fifo
   import tar_pkg::*;
#(
   parameter int WIDTH = TAR_ENTRY_W,
   parameter int DEPTH = TAR_DEPTH,
   parameter int PTR_W = TAR_PTR_W,
   parameter int CNT_W = TAR_CNT_W
) (
   input  wire logic             clock_in,
   input  wire logic             rst_n_in,
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic      [WIDTH-1:0] out_data_out,
   output logic      [CNT_W-1:0] count_out
);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PTR_W-1:0]            wr_ptr;
      logic [PTR_W-1:0]            rd_ptr;
      logic [CNT_W-1:0]            count;
   } tar_fifo_state_type;

   tar_fifo_state_type state_ff;
   tar_fifo_state_type nxt_state;
   logic               push;
   logic               pop;

   // Honest flags: full refuses writes, empty refuses reads
   assign in_ready_out  = (state_ff.count != CNT_W'(DEPTH));
   assign out_valid_out = (state_ff.count != '0);
   assign out_data_out  = state_ff.mem[state_ff.rd_ptr];
   assign count_out     = state_ff.count;
   assign push          = in_valid_in && in_ready_out;
   assign pop           = out_ready_in && out_valid_out;

   // Oldest entry leaves first; pointers wrap at the depth
   always_comb begin
      nxt_state = state_ff;
      if (push) begin
         nxt_state.mem[state_ff.wr_ptr] = in_data_in;
         nxt_state.wr_ptr = state_ff.wr_ptr + PTR_W'(1);
      end
      if (pop) begin
         nxt_state.rd_ptr = state_ff.rd_ptr + PTR_W'(1);
      end
      if (push && !pop) begin
         nxt_state.count = state_ff.count + CNT_W'(1);
      end else if (pop && !push) begin
         nxt_state.count = state_ff.count - CNT_W'(1);
      end
   end

   // State register
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   fifo_count_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      push && !pop |=> state_ff.count == $past(state_ff.count) + CNT_W'(1))
      else $error("fifo count did not grow on push");
endmodule : tar_fifo
`default_nettype wire

// ### tar_result_buffer.sv
// Result buffer of the touch ADC with its read-only host data word
`timescale 1ns/1ps
`default_nettype none
module tar_result_buffer
   import tar_pkg::*;
(
   input  wire logic                  clock_in,
   input  wire logic                  rst_n_in,
   input  wire logic                  buffer_mode_in,
   input  wire logic                  result_valid_in,
   output logic                       result_ready_out,
   input  wire logic [TAR_RES_W-1:0]  result_data_in,
   input  wire logic [3:0]            result_kind_in,
   input  wire logic                  read_strobe_in,
   input  wire logic                  write_strobe_in,
   input  wire logic [TAR_WORD_W-1:0] write_data_in,
   output logic      [TAR_WORD_W-1:0] read_data_out,
   output logic                       direct_valid_out,
   output logic      [TAR_RES_W-1:0]  direct_data_out,
   output logic      [3:0]            direct_kind_out
);
   typedef struct packed {
      logic [TAR_WORD_W-1:0] read_word;
      logic                  direct_valid;
      logic [TAR_RES_W-1:0]  direct_data;
      logic [3:0]            direct_kind;
   } tar_state_type;

   tar_state_type            state_ff;
   tar_state_type            nxt_state;
   logic                     result_tag;
   logic                     push;
   logic                     fifo_in_ready;
   logic                     fifo_out_valid;
   logic [TAR_ENTRY_W-1:0]   fifo_in_data;
   logic [TAR_ENTRY_W-1:0]   fifo_out_data;
   logic [TAR_CNT_W-1:0]     fifo_count;
   logic                     unused_write;

   // Host writes reach nothing; the stored word cannot be altered
   assign unused_write = write_strobe_in ^ (^write_data_in);

   // Source tag from the measurement kind
   always_comb begin
      case (result_kind_in)
         TAR_KIND_Y, TAR_KIND_PS2, TAR_KIND_AUX_ONE, TAR_KIND_TEMP: result_tag = 1'b1;
         default: result_tag = 1'b0;
      endcase
   end

   // Results enter in arrival order, so scan order is kept as produced
   assign fifo_in_data     = {result_tag, result_data_in};
   assign push             = result_valid_in && buffer_mode_in && fifo_in_ready;
   assign result_ready_out = buffer_mode_in ? fifo_in_ready : 1'b1;

   // Result store of 64 entries
   tar_fifo #(
      .WIDTH (TAR_ENTRY_W),
      .DEPTH (TAR_DEPTH),
      .PTR_W (TAR_PTR_W),
      .CNT_W (TAR_CNT_W)
   ) u_store (
      .clock_in      (clock_in),
      .rst_n_in      (rst_n_in),
      .in_valid_in   (result_valid_in && buffer_mode_in),
      .in_ready_out  (fifo_in_ready),
      .in_data_in    (fifo_in_data),
      .out_valid_out (fifo_out_valid),
      .out_ready_in  (read_strobe_in),
      .out_data_out  (fifo_out_data),
      .count_out     (fifo_count)
   );

   // Read word assembly and routing outside buffer mode
   always_comb begin
      nxt_state = state_ff;
      nxt_state.direct_valid = 1'b0;
      if (result_valid_in && !buffer_mode_in) begin
         nxt_state.direct_valid = 1'b1;
         nxt_state.direct_data  = result_data_in;
         nxt_state.direct_kind  = result_kind_in;
      end
      if (read_strobe_in) begin
         if (fifo_out_valid) begin
            // Oldest entry popped with this read
            nxt_state.read_word[TAR_TAG_BIT:0] = fifo_out_data;
         end
         nxt_state.read_word[TAR_FULL_BIT]  = (fifo_count == TAR_CNT_FULL);
         // Empty if the buffer was empty or nothing is left after this read; a store beside a read of the last entry refills
         nxt_state.read_word[TAR_EMPTY_BIT] = (fifo_count == TAR_CNT_ZERO) ||
                                              (fifo_count == TAR_CNT_ONE && !push);
         nxt_state.read_word[TAR_RSVD_BIT]  = 1'b0;
      end
   end

   // State register
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_ff <= '0;
         state_ff.read_word <= TAR_RESET_WORD;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign read_data_out    = state_ff.read_word;
   assign direct_valid_out = state_ff.direct_valid;
   assign direct_data_out  = state_ff.direct_data;
   assign direct_kind_out  = state_ff.direct_kind;

   reset_word_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      $past(rst_n_in) == 1'b0 |-> read_data_out == TAR_RESET_WORD)
      else $error("read word not empty after reset");

   host_write_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      write_strobe_in && !read_strobe_in |=> $stable(read_data_out))
      else $error("host write changed the read word");

   last_empty_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      read_strobe_in && fifo_count == TAR_CNT_ONE && !push |=> read_data_out[TAR_EMPTY_BIT]
      && read_data_out[TAR_TAG_BIT:0] == $past(fifo_out_data))
      else $error("last read did not show empty");

   refill_read_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      read_strobe_in && fifo_count == TAR_CNT_ONE && push |=> !read_data_out[TAR_EMPTY_BIT])
      else $error("empty shown although a store refilled the buffer");

   not_empty_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      read_strobe_in && fifo_count > TAR_CNT_ONE |=> !read_data_out[TAR_EMPTY_BIT])
      else $error("empty shown with data left");

   full_flag_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      read_strobe_in |=> read_data_out[TAR_FULL_BIT] == ($past(fifo_count) == TAR_CNT_FULL))
      else $error("full flag wrong");

   tag_map_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      push |-> fifo_in_data[TAR_TAG_BIT] == result_kind_in[0])
      else $error("source tag wrong for kind");

   mode_route_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      result_valid_in && buffer_mode_in |=> !direct_valid_out)
      else $error("buffer mode result went to direct path");

   direct_route_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      result_valid_in && !buffer_mode_in |-> !push ##1 direct_valid_out)
      else $error("direct result mishandled");

   empty_read_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      read_strobe_in && fifo_count == TAR_CNT_ZERO |=> read_data_out[TAR_EMPTY_BIT]
      && $stable(read_data_out[TAR_TAG_BIT:0]) && !read_data_out[TAR_RSVD_BIT])
      else $error("read of empty buffer wrong");
endmodule : tar_result_buffer
`default_nettype wire

// ### tar_host_model.sv
// Host model that reads the buffer word one strobe at a time
`timescale 1ns/1ps
`default_nettype none
module tar_host_model
   import tar_pkg::*;
(
   input  wire logic                  clock_in,
   input  wire logic [TAR_WORD_W-1:0] read_data_in,
   output logic                       read_strobe_out
);
   // Idle until a read is asked for
   initial read_strobe_out = 1'b0;

   // One-cycle strobe from a falling edge, word taken once it has landed
   task automatic read_word(output logic [TAR_WORD_W-1:0] word);
      @(negedge clock_in);
      read_strobe_out = 1'b1;
      @(negedge clock_in);
      read_strobe_out = 1'b0;
      word = read_data_in;
   endtask : read_word
endmodule : tar_host_model
`default_nettype wire

// ### tar_result_buffer_test.sv
// Self-checking bench of the touch ADC result buffer
`timescale 1ns/1ps
`default_nettype none
module tar_result_buffer_test
   import tar_pkg::*;
;
   typedef struct packed {logic [3:0] kind; logic [11:0] data; logic tag;} tar_row_type;
   logic        clock_in, rst_n_in, buffer_mode_in, result_valid_in, result_ready_out;
   logic [11:0] result_data_in, direct_data_out;
   logic [3:0]  result_kind_in, direct_kind_out;
   logic        read_strobe_in, write_strobe_in, direct_valid_out;
   logic [15:0] write_data_in, read_data_out, w;
   int          failures, checked;
   tar_row_type rows [8];

   tar_result_buffer dut_u (.clock_in(clock_in), .rst_n_in(rst_n_in),
      .buffer_mode_in(buffer_mode_in), .result_valid_in(result_valid_in),
      .result_ready_out(result_ready_out), .result_data_in(result_data_in),
      .result_kind_in(result_kind_in), .read_strobe_in(read_strobe_in),
      .write_strobe_in(write_strobe_in), .write_data_in(write_data_in),
      .read_data_out(read_data_out), .direct_valid_out(direct_valid_out),
      .direct_data_out(direct_data_out), .direct_kind_out(direct_kind_out));
   tar_host_model mdl_u (.clock_in(clock_in), .read_data_in(read_data_out),
      .read_strobe_out(read_strobe_in));

   // Clock of 5 ns period
   initial begin
      clock_in = 1'b0;
      forever #2.5 clock_in = ~clock_in;
   end

   task automatic check_word(input string name, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask : check_word

   task automatic check_bit(input string name, input logic exp, input logic got);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %b seen %b", name, exp, got);
      end
   endtask : check_bit

   // Offer one result and hold it until the edge that takes it
   task automatic push(input logic [3:0] kind, input logic [11:0] data);
      int n = 0;
      @(negedge clock_in);
      result_valid_in = 1'b1;
      result_kind_in = kind;
      result_data_in = data;
      while (result_ready_out !== 1'b1 && n < 100) begin
         @(negedge clock_in);
         n++;
      end
      if (n >= 100) begin
         failures++;
         $display("mismatch push ready expected 1 seen 0");
      end
      @(posedge clock_in);
   endtask : push

   task automatic report_and_stop;
      if (failures == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : report_and_stop

   // Watchdog against a hung handshake
   initial begin
      #20000;
      failures++;
      report_and_stop();
   end

   // Main sequence
   initial begin
      rows = '{'{4'h1, 12'hfff, 1'b1}, '{4'h0, 12'h000, 1'b0}, '{4'h2, 12'h123, 1'b0},
               '{4'h3, 12'h456, 1'b1}, '{4'h4, 12'h789, 1'b0}, '{4'h5, 12'habc, 1'b1},
               '{4'h6, 12'hdef, 1'b0}, '{4'h7, 12'h801, 1'b1}};
      {rst_n_in, buffer_mode_in, result_valid_in, write_strobe_in} = 4'h0;
      result_data_in = 12'h000;
      result_kind_in = 4'h0;
      write_data_in = 16'h0000;
      failures = 0;
      checked = 0;
      repeat (12) @(posedge clock_in);
      check_word("reset word", 16'h4000, read_data_out);
      @(negedge clock_in);
      rst_n_in = 1'b1;
      buffer_mode_in = 1'b1;
      // Ordinary cases: one result of each kind, read back in order
      foreach (rows[i]) push(rows[i].kind, rows[i].data);
      @(negedge clock_in);
      result_valid_in = 1'b0;
      foreach (rows[i]) begin
         mdl_u.read_word(w);
         check_word("row word", {1'b0, i == 7, 1'b0, rows[i].tag, rows[i].data}, w);
      end
      // Fill all locations, then one more is refused and a write is ignored
      for (int i = 0; i < 64; i++) push({1'b0, i[2:0]}, i[11:0]);
      @(negedge clock_in);
      result_data_in = 12'habc;
      write_strobe_in = 1'b1;
      write_data_in = 16'hffff;
      @(negedge clock_in);
      write_strobe_in = 1'b0;
      @(negedge clock_in);
      check_bit("ready when full", 1'b0, result_ready_out);
      result_valid_in = 1'b0;
      for (int i = 0; i < 64; i++) begin
         mdl_u.read_word(w);
         check_word("fill word", {i == 0, i == 63, 1'b0, i[0], i[11:0]}, w);
      end
      mdl_u.read_word(w);
      check_word("empty read", 16'h503f, w);
      // Outside buffer mode the result goes to the direct outputs
      buffer_mode_in = 1'b0;
      push(TAR_KIND_TEMP, 12'h5a5);
      @(negedge clock_in);
      result_valid_in = 1'b0;
      check_bit("direct valid", 1'b1, direct_valid_out);
      check_word("direct result", 16'h75a5, {direct_kind_out, direct_data_out});
      buffer_mode_in = 1'b1;
      mdl_u.read_word(w);
      check_word("flags after direct", 16'h4000, w & 16'hc000);
      // Read and store in one cycle with one entry left: not yet empty
      push(TAR_KIND_X, 12'h111);
      fork
         push(TAR_KIND_Y, 12'h222);
         mdl_u.read_word(w);
      join
      result_valid_in = 1'b0;
      check_word("read beside store", 16'h0111, w);
      mdl_u.read_word(w);
      check_word("stored beside read", 16'h5222, w);
      // Reset in mid-run flushes the stored entries and restores the word
      push(TAR_KIND_PS1, 12'h333);
      push(TAR_KIND_PS2, 12'h444);
      @(negedge clock_in);
      result_valid_in = 1'b0;
      rst_n_in = 1'b0;
      @(negedge clock_in);
      check_word("mid reset word", TAR_RESET_WORD, read_data_out);
      repeat (2) @(negedge clock_in);
      rst_n_in = 1'b1;
      mdl_u.read_word(w);
      check_word("read after reset", 16'h4000, w & 16'hc000);
      report_and_stop();
   end
endmodule : tar_result_buffer_test
`default_nettype wire
